// >>> rtl/hww_pkg.sv
// Constants, register map and the power-state enum of the halt, wake-up and watchdog block
// Assumes a single 200 MHz clock and a synchronous low-speed oscillator tick
package hww_pkg;

  // ****************************************
  // Clock and timing
  // ****************************************
  localparam int CLK_PERIOD_PS = 5000;
  localparam int SOFT_RESET_DELAY_NS = 1000;
  localparam int SOFT_RESET_DELAY_CYC = (SOFT_RESET_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int LOW_SPEED_INTERNAL_OSC_NOMINAL_HZ = 32000;

  // ****************************************
  // Register bus
  // ****************************************
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] OFS_SYS_CLK_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_WDT_CTRL = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_RST_CAUSE = 4'h2;
  localparam logic [ADDR_W-1:0] OFS_PA_WAKE = 4'h3;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h4;

  // ****************************************
  // Field layout
  // ****************************************
  localparam int SCC_HIGH_HOLD_BIT = 1;
  localparam int SCC_LOW_HOLD_BIT = 0;
  localparam int WDT_EN_MSB = 7;
  localparam int WDT_EN_LSB = 3;
  localparam int WDT_SEL_MSB = 2;
  localparam int WDT_SEL_LSB = 0;
  localparam int RCF_WRF_BIT = 0;
  localparam int STAT_PDF_BIT = 1;
  localparam int STAT_TO_BIT = 0;

  // ****************************************
  // Codes and reset values
  // ****************************************
  localparam logic [4:0] WDT_EN_DISABLE = 5'h15;
  localparam logic [4:0] WDT_EN_ENABLE = 5'h0a;
  localparam logic [7:0] WDT_CTRL_RST = 8'h53;
  localparam logic [1:0] SCC_RST = 2'h0;
  localparam logic [7:0] PA_WAKE_RST = 8'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;

  // ****************************************
  // Watchdog period table
  // ****************************************
  localparam int WDT_CNT_W = 18;
  localparam logic [WDT_CNT_W-1:0] WDT_LIM_0 = 18'h000ff;
  localparam logic [WDT_CNT_W-1:0] WDT_LIM_1 = 18'h003ff;
  localparam logic [WDT_CNT_W-1:0] WDT_LIM_2 = 18'h00fff;
  localparam logic [WDT_CNT_W-1:0] WDT_LIM_3 = 18'h03fff;
  localparam logic [WDT_CNT_W-1:0] WDT_LIM_4 = 18'h07fff;
  localparam logic [WDT_CNT_W-1:0] WDT_LIM_5 = 18'h0ffff;
  localparam logic [WDT_CNT_W-1:0] WDT_LIM_6 = 18'h1ffff;
  localparam logic [WDT_CNT_W-1:0] WDT_LIM_7 = 18'h3ffff;

  // ****************************************
  // Power state
  // ****************************************
  typedef enum logic [1:0] {
    HWW_ST_RUN = 2'b00,
    HWW_ST_HALT = 2'b01,
    HWW_ST_WAKE = 2'b11
  } hww_state_e;

endpackage

// >>> rtl/hww_wdt_if.sv
// Link between the power-down controller and the watchdog counter
// Assumes both ends run on the same clock
`timescale 1ns/100ps
interface hww_wdt_if;
  import hww_pkg::*;
  logic tick;
  logic run;
  logic clear;
  logic [2:0] period_sel;
  logic overflow;
  modport ctl (output tick, output run, output clear, output period_sel, input overflow);
  modport cnt (input tick, input run, input clear, input period_sel, output overflow);
endinterface

// >>> rtl/hww_wdt_counter.sv
// Watchdog counter: counts oscillator ticks up to a selected power of two
// Assumes tick is a one-cycle pulse synchronous to clk
`timescale 1ns/100ps
module hww_wdt_counter
  import hww_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control link
  hww_wdt_if.cnt wd
);

  logic [WDT_CNT_W-1:0] cnt_r;
  logic [WDT_CNT_W-1:0] lim;
  logic ovf_r;

  // ****************************************
  // Period decode
  // ****************************************
  always_comb
  begin
    case (wd.period_sel)
      3'h0: lim = WDT_LIM_0;
      3'h1: lim = WDT_LIM_1;
      3'h2: lim = WDT_LIM_2;
      3'h3: lim = WDT_LIM_3;
      3'h4: lim = WDT_LIM_4;
      3'h5: lim = WDT_LIM_5;
      3'h6: lim = WDT_LIM_6;
      default: lim = WDT_LIM_7;
    endcase
  end

  // ****************************************
  // Count and overflow
  // ****************************************
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_r <= '0;
      ovf_r <= 1'b0;
    end
    else
    begin
      ovf_r <= 1'b0;
      if (wd.clear)
      begin
        cnt_r <= '0;
      end
      else if (wd.run && wd.tick)
      begin
        if (cnt_r >= lim)
        begin
          cnt_r <= '0;
          ovf_r <= 1'b1;
        end
        else
        begin
          cnt_r <= cnt_r + 1'b1;
        end
      end
    end
  end

  assign wd.overflow = ovf_r;

endmodule

// >>> rtl/hww_top.sv
// Halt, wake-up and watchdog control of a small microcontroller
// Assumes CPU strobes are one-cycle pulses synchronous to clk; low_speed_internal_osc_tick is
// a one-cycle pulse per low-speed oscillator period
//
// Added by the designer: strobed register access and the register offsets.
`timescale 1ns/100ps
module hww_top
  import hww_pkg::*;
#(
  parameter int PA_W = 8,
  parameter int IRQ_W = 8,
  parameter int SRST_DELAY_CYC = SOFT_RESET_DELAY_CYC
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  // CPU core
  input wire logic halt_exec,
  input wire logic clear_watchdog_exec,
  input wire logic stack_full,
  input wire logic [IRQ_W-1:0] irq_req,
  input wire logic [IRQ_W-1:0] irq_en,
  // Port A and oscillator
  input wire logic [PA_W-1:0] port_a_pin,
  input wire logic low_speed_internal_osc_tick,
  // Clock gating
  output logic cpu_halted,
  output logic high_clock_run,
  output logic sub_clock_run,
  output logic low_speed_internal_osc_run,
  output logic deep_sleep,
  // Wake and reset actions
  output logic resume_after_halt,
  output logic irq_respond,
  output logic pc_sp_reset,
  output logic device_reset,
  // Status flags
  output logic power_down_flag,
  output logic timeout_flag
);

  localparam int SRST_W = $clog2(SRST_DELAY_CYC + 1);
  localparam logic [SRST_W-1:0] SRST_LAST = SRST_W'(SRST_DELAY_CYC - 1);

  hww_wdt_if wd ();

  hww_state_e state_r;
  hww_state_e state_nxt;
  logic [1:0] scc_r;
  logic [4:0] wdt_en_r;
  logic [2:0] wdt_sel_r;
  logic [PA_W-1:0] pa_wake_r;
  logic [PA_W-1:0] pin_prev_r;
  logic [IRQ_W-1:0] irq_pre_r;
  logic wrf_r;
  logic pdf_r;
  logic to_r;
  logic [DATA_W-1:0] rdata_r;
  logic srst_busy_r;
  logic [SRST_W-1:0] srst_cnt_r;
  logic halted_r;
  logic hclk_r;
  logic sclk_r;
  logic low_speed_internal_osc_r;
  logic sleep_r;
  logic resume_r;
  logic irq_rsp_r;
  logic pcsp_r;
  logic dev_rst_r;
  logic [4:0] wr_en_field;
  logic wdt_ctrl_wr;
  logic illegal_wr;
  logic wdt_enabled;
  logic halt_entry;
  logic pin_wake;
  logic [IRQ_W-1:0] irq_new;
  logic irq_wake;
  logic irq_serve;
  logic wdt_wake;
  logic any_wake;
  logic srst_done;

  // ****************************************
  // Decode
  // ****************************************
  assign wr_en_field = reg_wdata[WDT_EN_MSB:WDT_EN_LSB];
  assign wdt_ctrl_wr = reg_wr && (reg_addr == OFS_WDT_CTRL);
  assign illegal_wr = wdt_ctrl_wr && (wr_en_field != WDT_EN_DISABLE) && (wr_en_field != WDT_EN_ENABLE);
  assign wdt_enabled = (wdt_en_r == WDT_EN_ENABLE);
  assign halt_entry = (state_r == HWW_ST_RUN) && halt_exec;
  assign pin_wake = |(pin_prev_r & ~port_a_pin & pa_wake_r);
  assign irq_new = irq_req & ~irq_pre_r;
  assign irq_wake = |irq_new;
  assign irq_serve = (|(irq_new & irq_en)) && !stack_full;
  assign wdt_wake = wd.overflow;
  assign any_wake = pin_wake || irq_wake || wdt_wake;
  assign srst_done = srst_busy_r && (srst_cnt_r == SRST_LAST);

  // ****************************************
  // Watchdog link
  // ****************************************
  assign wd.tick = low_speed_internal_osc_tick && low_speed_internal_osc_r;
  assign wd.run = wdt_enabled;
  assign wd.clear = halt_entry || clear_watchdog_exec || illegal_wr;
  assign wd.period_sel = wdt_sel_r;

  hww_wdt_counter u_wdt
  (
    .clk(clk),
    .rst(rst),
    .wd(wd)
  );

  // ****************************************
  // Power state machine
  // ****************************************
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      HWW_ST_RUN:
      begin
        if (halt_exec)
        begin
          state_nxt = HWW_ST_HALT;
        end
      end
      HWW_ST_HALT:
      begin
        if (any_wake)
        begin
          state_nxt = HWW_ST_WAKE;
        end
      end
      HWW_ST_WAKE:
      begin
        state_nxt = HWW_ST_RUN;
      end
      default:
      begin
        state_nxt = HWW_ST_RUN;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_r <= HWW_ST_RUN;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  // ****************************************
  // Clock gating
  // ****************************************
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      halted_r <= 1'b0;
      hclk_r <= 1'b1;
      sclk_r <= 1'b1;
      low_speed_internal_osc_r <= 1'b1;
      sleep_r <= 1'b0;
    end
    else if (halt_entry)
    begin
      halted_r <= 1'b1;
      hclk_r <= scc_r[SCC_HIGH_HOLD_BIT];
      sclk_r <= scc_r[SCC_LOW_HOLD_BIT];
      low_speed_internal_osc_r <= scc_r[SCC_LOW_HOLD_BIT] || wdt_enabled;
      sleep_r <= !scc_r[SCC_HIGH_HOLD_BIT] && !scc_r[SCC_LOW_HOLD_BIT];
    end
    else if (state_r == HWW_ST_HALT)
    begin
      low_speed_internal_osc_r <= sclk_r || wdt_enabled;
      if (any_wake)
      begin
        halted_r <= 1'b0;
        hclk_r <= 1'b1;
        sclk_r <= 1'b1;
        low_speed_internal_osc_r <= 1'b1;
        sleep_r <= 1'b0;
      end
    end
  end

  // ****************************************
  // Pin edge and pending request capture
  // ****************************************
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pin_prev_r <= '0;
    end
    else
    begin
      pin_prev_r <= port_a_pin;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      irq_pre_r <= '0;
    end
    else if (halt_entry)
    begin
      irq_pre_r <= irq_req;
    end
    else if (state_r == HWW_ST_HALT)
    begin
      irq_pre_r <= irq_pre_r & irq_req;
    end
  end

  // ****************************************
  // Wake actions
  // ****************************************
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      resume_r <= 1'b0;
      irq_rsp_r <= 1'b0;
      pcsp_r <= 1'b0;
    end
    else
    begin
      resume_r <= 1'b0;
      irq_rsp_r <= 1'b0;
      pcsp_r <= 1'b0;
      if ((state_r == HWW_ST_HALT) && any_wake)
      begin
        if (wdt_wake)
        begin
          pcsp_r <= 1'b1;
        end
        else if (irq_wake && irq_serve)
        begin
          irq_rsp_r <= 1'b1;
        end
        else
        begin
          resume_r <= 1'b1;
        end
      end
    end
  end

  // ****************************************
  // Soft reset delay and device reset
  // ****************************************
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      srst_busy_r <= 1'b0;
      srst_cnt_r <= '0;
    end
    else if (illegal_wr)
    begin
      srst_busy_r <= 1'b1;
      srst_cnt_r <= '0;
    end
    else if (srst_done)
    begin
      srst_busy_r <= 1'b0;
    end
    else if (srst_busy_r)
    begin
      srst_cnt_r <= srst_cnt_r + 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      dev_rst_r <= 1'b0;
    end
    else
    begin
      dev_rst_r <= srst_done || (wd.overflow && (state_r != HWW_ST_HALT));
    end
  end

  // ****************************************
  // Status flags
  // ****************************************
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pdf_r <= 1'b0;
    end
    else if (halt_entry)
    begin
      pdf_r <= 1'b1;
    end
    else if (clear_watchdog_exec)
    begin
      pdf_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      to_r <= 1'b0;
    end
    else if (wd.overflow)
    begin
      to_r <= 1'b1;
    end
    else if (halt_entry)
    begin
      to_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wrf_r <= 1'b0;
    end
    else if (srst_done)
    begin
      wrf_r <= 1'b1;
    end
    else if (reg_wr && (reg_addr == OFS_RST_CAUSE) && !reg_wdata[RCF_WRF_BIT])
    begin
      wrf_r <= 1'b0;
    end
  end

  // ****************************************
  // Control registers
  // ****************************************
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      scc_r <= SCC_RST;
      pa_wake_r <= PA_W'(PA_WAKE_RST);
    end
    else if (reg_wr)
    begin
      if (reg_addr == OFS_SYS_CLK_CTRL)
      begin
        scc_r <= reg_wdata[SCC_HIGH_HOLD_BIT:SCC_LOW_HOLD_BIT];
      end
      if (reg_addr == OFS_PA_WAKE)
      begin
        pa_wake_r <= reg_wdata[PA_W-1:0];
      end
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wdt_en_r <= WDT_CTRL_RST[WDT_EN_MSB:WDT_EN_LSB];
      wdt_sel_r <= WDT_CTRL_RST[WDT_SEL_MSB:WDT_SEL_LSB];
    end
    else if (wdt_ctrl_wr)
    begin
      wdt_en_r <= wr_en_field;
      wdt_sel_r <= reg_wdata[WDT_SEL_MSB:WDT_SEL_LSB];
    end
  end

  // ****************************************
  // Read port
  // ****************************************
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rdata_r <= READ_ZERO;
    end
    else
    begin
      rdata_r <= READ_ZERO;
      if (reg_rd)
      begin
        case (reg_addr)
          OFS_SYS_CLK_CTRL: rdata_r <= {6'h00, scc_r};
          OFS_WDT_CTRL: rdata_r <= {wdt_en_r, wdt_sel_r};
          OFS_RST_CAUSE: rdata_r <= {7'h00, wrf_r};
          OFS_PA_WAKE: rdata_r <= DATA_W'(pa_wake_r);
          OFS_STATUS: rdata_r <= {6'h00, pdf_r, to_r};
          default: rdata_r <= READ_ZERO;
        endcase
      end
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign reg_rdata = rdata_r;
  assign cpu_halted = halted_r;
  assign high_clock_run = hclk_r;
  assign sub_clock_run = sclk_r;
  assign low_speed_internal_osc_run = low_speed_internal_osc_r;
  assign deep_sleep = sleep_r;
  assign resume_after_halt = resume_r;
  assign irq_respond = irq_rsp_r;
  assign pc_sp_reset = pcsp_r;
  assign device_reset = dev_rst_r;
  assign power_down_flag = pdf_r;
  assign timeout_flag = to_r;

endmodule

// >>> bench/hww_props.sv
// Checker of the halt, wake-up and watchdog block
// Assumes it is bound to hww_top and sees only its ports
`timescale 1ns/100ps
module hww_props
  import hww_pkg::*;
#(
  parameter int PA_W = 8,
  parameter int IRQ_W = 8,
  parameter int SRST_DELAY_CYC = SOFT_RESET_DELAY_CYC
)
(
  // Clock, reset, register port
  input wire logic clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata,
  // CPU core, pins, oscillator
  input wire logic halt_exec,
  input wire logic clear_watchdog_exec,
  input wire logic stack_full,
  input wire logic [IRQ_W-1:0] irq_req,
  input wire logic [IRQ_W-1:0] irq_en,
  input wire logic [PA_W-1:0] port_a_pin,
  input wire logic low_speed_internal_osc_tick,
  // Block outputs
  input wire logic cpu_halted,
  input wire logic high_clock_run,
  input wire logic sub_clock_run,
  input wire logic low_speed_internal_osc_run,
  input wire logic deep_sleep,
  input wire logic resume_after_halt,
  input wire logic irq_respond,
  input wire logic pc_sp_reset,
  input wire logic device_reset,
  input wire logic power_down_flag,
  input wire logic timeout_flag
);
  localparam int SRST_LIM = SRST_DELAY_CYC + 4;
  logic [1:0] scc_r;
  logic wden_r;
  logic [PA_W-1:0] pa_r;
  logic [IRQ_W-1:0] pend_r;
  logic wake_any;
  logic accept;
  assign wake_any = resume_after_halt || irq_respond || pc_sp_reset;
  assign accept = halt_exec && !cpu_halted && !wake_any;

  // Shadow of the written control fields
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      scc_r <= SCC_RST;
      wden_r <= 1'b1;
      pa_r <= '0;
    end
    else if (reg_wr && reg_addr == OFS_SYS_CLK_CTRL)
      scc_r <= reg_wdata[1:0];
    else if (reg_wr && reg_addr == OFS_WDT_CTRL)
      wden_r <= reg_wdata[7:3] == WDT_EN_ENABLE;
    else if (reg_wr && reg_addr == OFS_PA_WAKE)
      pa_r <= reg_wdata[PA_W-1:0];
  end

  // Requests already pending at halt entry
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      pend_r <= '0;
    else if (accept)
      pend_r <= irq_req;
    else
      pend_r <= pend_r & irq_req;
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_pin_fall;
    cpu_halted && |($past(port_a_pin) & ~port_a_pin & pa_r);
  endsequence
  sequence s_bad_wr;
    reg_wr && reg_addr == OFS_WDT_CTRL && reg_wdata[7:3] != WDT_EN_ENABLE && reg_wdata[7:3] != WDT_EN_DISABLE;
  endsequence

  AST_HALT_FLAGS: assert property (accept |=> cpu_halted && power_down_flag && !timeout_flag)
    else $error("halt entry flags wrong");
  AST_HALT_CLOCKS: assert property (accept |=> high_clock_run == scc_r[1] && sub_clock_run == scc_r[0]
    && deep_sleep == (scc_r == 2'h0)) else $error("halt clock gating wrong");
  AST_LOW_SPEED_INTERNAL_OSC_ON: assert property ($rose(cpu_halted) |-> low_speed_internal_osc_run == (scc_r[0] || wden_r))
    else $error("low-speed oscillator state wrong");
  AST_WAKE_ONE: assert property ($fell(cpu_halted) |-> high_clock_run && sub_clock_run
    && $onehot({resume_after_halt, irq_respond, pc_sp_reset})) else $error("wake exit wrong");
  AST_PIN_WAKE: assert property (s_pin_fall |-> ##[1:2] !cpu_halted)
    else $error("pin wake missed");
  AST_PDF_CLR: assert property (clear_watchdog_exec && !halt_exec && !cpu_halted |=> !power_down_flag)
    else $error("power-down flag not cleared");
  AST_IRQ_WAKE: assert property (cpu_halted && |(irq_req & ~pend_r & irq_en) && !stack_full
    |-> ##[1:2] (irq_respond || pc_sp_reset)) else $error("interrupt response missed");
  AST_OVF_HALT: assert property (pc_sp_reset |-> ($past(cpu_halted) && power_down_flag) ##[0:1] timeout_flag)
    else $error("halt overflow flags wrong");
  AST_TO_CAUSE: assert property ($rose(timeout_flag) |-> (##[0:1] (device_reset || pc_sp_reset))
    or $past(device_reset || pc_sp_reset)) else $error("time-out flag without overflow action");
  AST_SOFT_RST: assert property (s_bad_wr |-> ##[2:SRST_LIM] device_reset)
    else $error("soft reset missing");
endmodule

// >>> bench/hww_cpu_model.sv
// CPU core model: turns bench commands into instruction strobes
// Assumes the block's status outputs are registered on clk
`timescale 1ns/100ps
module hww_cpu_model
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Bench commands
  input wire logic cmd_halt,
  input wire logic cmd_clr,
  input wire logic kick_en,
  // Block status
  input wire logic cpu_halted,
  input wire logic wake_any,
  // Instruction strobes
  output logic halt_exec,
  output logic clear_watchdog_exec
);
  logic [6:0] kick_r;
  logic busy;
  // A halted or waking core executes nothing
  assign busy = cpu_halted || wake_any || halt_exec || clear_watchdog_exec;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      halt_exec <= 1'b0;
      clear_watchdog_exec <= 1'b0;
      kick_r <= 7'h00;
    end
    else
    begin
      kick_r <= kick_r + 7'h01;
      halt_exec <= cmd_halt && !busy;
      clear_watchdog_exec <= !busy && (cmd_clr || (kick_en && kick_r == 7'h00));
    end
  end
endmodule

// >>> bench/hww_top_tb.sv
// Self-checking bench of the halt, wake-up and watchdog block
// Assumes hww_pkg, hww_top and the CPU model are compiled first
`timescale 1ns/100ps
module hww_top_tb;
  import hww_pkg::*;
  localparam int SRST = 2;
  localparam logic [3:0] RA [6] = '{OFS_SYS_CLK_CTRL, OFS_WDT_CTRL, OFS_RST_CAUSE, OFS_PA_WAKE, OFS_STATUS, 4'hf};
  localparam logic [7:0] RV [6] = '{8'(SCC_RST), WDT_CTRL_RST, READ_ZERO, PA_WAKE_RST, READ_ZERO, READ_ZERO};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic cmd_halt = 1'b0;
  logic cmd_clr = 1'b0;
  logic kick_en = 1'b0;
  logic halt_exec, clear_watchdog_exec;
  logic stack_full = 1'b0;
  logic [7:0] irq_req = 8'h00;
  logic [7:0] irq_en = 8'h00;
  logic [7:0] port_a_pin = 8'hff;
  logic low_speed_internal_osc_tick = 1'b0;
  logic cpu_halted, high_clock_run, sub_clock_run, low_speed_internal_osc_run, deep_sleep;
  logic resume_after_halt, irq_respond, pc_sp_reset, device_reset, power_down_flag, timeout_flag;
  logic [7:0] d;
  logic [7:0] en;
  logic [7:0] lfsr_r = 8'h55;
  int n;
  int cyc = 0;
  int fail_count = 0;
  int comparisons = 0;

  hww_top #(.SRST_DELAY_CYC(SRST)) dut_u (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .halt_exec(halt_exec),
    .clear_watchdog_exec(clear_watchdog_exec), .stack_full(stack_full), .irq_req(irq_req), .irq_en(irq_en),
    .port_a_pin(port_a_pin), .low_speed_internal_osc_tick(low_speed_internal_osc_tick), .cpu_halted(cpu_halted), .high_clock_run(high_clock_run),
    .sub_clock_run(sub_clock_run), .low_speed_internal_osc_run(low_speed_internal_osc_run), .deep_sleep(deep_sleep),
    .resume_after_halt(resume_after_halt), .irq_respond(irq_respond), .pc_sp_reset(pc_sp_reset),
    .device_reset(device_reset), .power_down_flag(power_down_flag), .timeout_flag(timeout_flag));
  hww_cpu_model cpu_u (.clk(clk), .rst(rst), .cmd_halt(cmd_halt), .cmd_clr(cmd_clr), .kick_en(kick_en),
    .cpu_halted(cpu_halted), .wake_any(resume_after_halt || irq_respond || pc_sp_reset),
    .halt_exec(halt_exec), .clear_watchdog_exec(clear_watchdog_exec));

  // ********
  // Clock, oscillator tick, time limit
  // ********
  always #2.5 clk = ~clk;
  always @(posedge clk) low_speed_internal_osc_tick <= !low_speed_internal_osc_tick;
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fail_count++;
      finish_test();
    end
  end

  // ********
  // Helpers
  // ********
  function automatic logic [7:0] lfsr_next(input logic [7:0] v);
    lfsr_next = {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    comparisons++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask
  task automatic cmd(input logic h);
    @(posedge clk);
    if (h) cmd_halt <= 1'b1;
    else cmd_clr <= 1'b1;
    @(posedge clk);
    cmd_halt <= 1'b0;
    cmd_clr <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask
  // Event index: 0 resume, 1 interrupt response, 2 pc/sp reset, 3 device reset
  task automatic wait_ev(input int k, input int lim, input logic exp, output int cnt);
    logic [3:0] ev;
    logic hit;
    hit = 1'b0;
    cnt = 0;
    while (!hit && cnt < lim)
    begin
      @(posedge clk);
      #1;
      ev = {device_reset, pc_sp_reset, irq_respond, resume_after_halt};
      hit = ev[k] === 1'b1;
      cnt++;
    end
    chk1(hit, exp);
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ********
  // Main sequence
  // ********
  initial
  begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    wr(4'hf, 8'hff);
    for (int i = 0; i < 6; i++)
    begin
      rd(RA[i], d);
      chk8(d, RV[i]);
    end
    $display("test reset values done");
    wr(OFS_WDT_CTRL, {WDT_EN_DISABLE, 3'h0});
    for (int m = 0; m < 4; m++)
    begin
      lfsr_r = lfsr_next(lfsr_r);
      en = (lfsr_r & 8'hfc) | 8'h01;
      wr(OFS_SYS_CLK_CTRL, 8'(m));
      wr(OFS_PA_WAKE, en);
      cmd(1'b1);
      chk1(cpu_halted, 1'b1);
      chk1(high_clock_run, m[1]);
      chk1(sub_clock_run, m[0]);
      chk1(deep_sleep, m == 0);
      chk1(low_speed_internal_osc_run, m[0]);
      chk1(power_down_flag & ~timeout_flag, 1'b1);
      @(posedge clk) port_a_pin <= 8'hfd;
      wait_ev(0, 10, 1'b0, n);
      @(posedge clk) port_a_pin <= 8'hfc;
      wait_ev(0, 10, 1'b1, n);
      @(posedge clk) port_a_pin <= 8'hff;
      rd(OFS_WDT_CTRL, d);
      chk8(d, {WDT_EN_DISABLE, 3'h0});
      cmd(1'b0);
      chk1(power_down_flag, 1'b0);
    end
    $display("test halt modes and pin wake done");
    @(posedge clk) irq_en <= 8'hff;
    irq_req <= 8'h04;
    cmd(1'b1);
    wait_ev(1, 20, 1'b0, n);
    @(posedge clk) irq_req <= 8'h00;
    @(posedge clk) irq_req <= 8'h04;
    wait_ev(1, 10, 1'b1, n);
    @(posedge clk) irq_req <= 8'h00;
    stack_full <= 1'b1;
    cmd(1'b1);
    @(posedge clk) irq_req <= 8'h10;
    wait_ev(0, 10, 1'b1, n);
    @(posedge clk) irq_req <= 8'h00;
    stack_full <= 1'b0;
    $display("test interrupt wake done");
    wr(OFS_SYS_CLK_CTRL, 8'h00);
    wr(OFS_WDT_CTRL, {WDT_EN_ENABLE, 3'h0});
    cmd(1'b1);
    chk1(low_speed_internal_osc_run & ~sub_clock_run, 1'b1);
    wait_ev(2, 600, 1'b1, n);
    chk1(n >= 506 && n <= 518, 1'b1);
    chk1(timeout_flag & power_down_flag, 1'b1);
    $display("test overflow in halt done");
    @(posedge clk) rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk1(power_down_flag | timeout_flag, 1'b0);
    wr(OFS_WDT_CTRL, {WDT_EN_ENABLE, 3'h1});
    kick_en <= 1'b1;
    wait_ev(3, 3000, 1'b0, n);
    @(posedge clk) kick_en <= 1'b0;
    cmd(1'b0);
    wait_ev(3, 2200, 1'b1, n);
    chk1(n >= 2040 && n <= 2056, 1'b1);
    chk1(timeout_flag, 1'b1);
    $display("test overflow in run done");
    wr(OFS_WDT_CTRL, 8'hff);
    wait_ev(3, 20, 1'b1, n);
    cmd(1'b0);
    wr(OFS_RST_CAUSE, 8'h01);
    rd(OFS_RST_CAUSE, d);
    chk8(d, 8'h01);
    wr(OFS_RST_CAUSE, 8'h00);
    rd(OFS_RST_CAUSE, d);
    chk8(d, 8'h00);
    $display("test soft reset done");
    finish_test();
  end
endmodule

bind hww_top hww_props #(.PA_W(PA_W), .IRQ_W(IRQ_W), .SRST_DELAY_CYC(SRST_DELAY_CYC)) props_u (.clk(clk),
  .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .halt_exec(halt_exec), .clear_watchdog_exec(clear_watchdog_exec),
  .stack_full(stack_full), .irq_req(irq_req), .irq_en(irq_en), .port_a_pin(port_a_pin),
  .low_speed_internal_osc_tick(low_speed_internal_osc_tick), .cpu_halted(cpu_halted), .high_clock_run(high_clock_run),
  .sub_clock_run(sub_clock_run), .low_speed_internal_osc_run(low_speed_internal_osc_run), .deep_sleep(deep_sleep),
  .resume_after_halt(resume_after_halt), .irq_respond(irq_respond), .pc_sp_reset(pc_sp_reset),
  .device_reset(device_reset), .power_down_flag(power_down_flag), .timeout_flag(timeout_flag));
